// file: logic/fuse_trim_key_programmer.sv
`timescale 1ns/1ps
`include "fuse_trim_defines.svh"

module fuse_trim_key_programmer
  import fuse_trim_pkg::*;
(
  // clock and power-cycle reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // supply pin level and virgin fuse erase
  input  wire logic [1:0]             supply_level,
  input  wire logic                   fuse_erase,
  // analog fuse sense at high and low thresholds
  input  wire logic [`FUSE_COUNT-1:0] fuse_sense_high,
  input  wire logic [`FUSE_COUNT-1:0] fuse_sense_low,
  // register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  // trim outputs to the analog path
  output logic [5:0]                  operate_point,
  output logic [1:0]                  switch_hysteresis,
  output logic                        parity_trim,
  output logic                        supply_current_bump,
  // fuse blow drive
  output logic                        fuse_blow_pulse,
  output logic [`FUSE_COUNT-1:0]      fuse_blow_sel
);

  key_state_t              state;
  reg_sel_t                sel;
  check_t                  check_mode;
  logic [1:0]              high_count;
  logic [3:0]              mid_count;
  logic [7:0]              blow_addr;
  logic                    blow_done;
  logic                    try_on;
  logic [5:0]              trial_op;
  logic [1:0]              trial_hys;
  logic                    trial_par;
  logic [`FUSE_COUNT-1:0]  fuse;
  logic                    marginal;
  logic                    key_disable;
  logic                    mid_event;
  logic                    high_event;
  logic                    blow_event;
  logic                    locked;
  logic                    mid_ev;
  logic                    high_ev;
  logic                    blow_ev;
  logic [3:0]              next_mid_count;

  // decode a completed first key part into a register
  function automatic reg_sel_t decode_key(input logic [1:0] highs, input logic [3:0] mids);
    reg_sel_t r;
    r = SEL_NONE;
    if (highs == 2'h2) begin
      if (mids == `KEY_MID_DOWN) r = SEL_OP_DOWN;
      else if (mids == `KEY_MID_BITWISE) r = SEL_OP_BIT;
      else if (mids == `KEY_MID_BLOW) r = SEL_OP_BLOW;
    end else begin
      if (mids == `KEY_MID_HYS) r = SEL_HYS;
      else if (mids == `KEY_MID_PARITY) r = SEL_PARITY;
      else if (mids == `KEY_MID_LOCK) r = SEL_LOCK;
    end
    return r;
  endfunction : decode_key

  // saturating pulse counter step
  function automatic logic [3:0] count_up(input logic [3:0] c);
    return (c == 4'hf) ? c : c + 4'h1;
  endfunction : count_up

  // one-hot walk with a zero code after the top bit
  function automatic logic [5:0] bit_step(input logic [5:0] c);
    logic [5:0] n;
    n = (c == 6'h00) ? 6'h01 : {c[4:0], 1'b0};
    return n;
  endfunction : bit_step

  supply_pulse_classifier u_classifier (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .supply_level (supply_level),
    .mid_event    (mid_event),
    .high_event   (high_event),
    .blow_event   (blow_event)
  );

  // events gated by software disable
  assign locked         = fuse[`FUSE_LOCK_BIT];
  assign mid_ev         = mid_event && !key_disable;
  assign high_ev        = high_event && !key_disable;
  assign blow_ev        = blow_event && !key_disable;
  assign next_mid_count = count_up(mid_count);

  // key tracking state machine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state      <= ST_IDLE;
      sel        <= SEL_NONE;
      high_count <= 2'h0;
      mid_count  <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (high_ev) begin
            state      <= ST_HIGH;
            high_count <= 2'h1;
          end
        end
        ST_HIGH: begin
          if (high_ev && high_count == 2'h1) begin
            state      <= ST_MID1;
            high_count <= 2'h2;
            mid_count  <= 4'h0;
            sel        <= locked ? SEL_NONE : SEL_OP_UP;
          end else if (high_ev) begin
            state <= ST_DEAD;
          end else if (mid_ev) begin
            state     <= ST_MID1;
            mid_count <= 4'h1;
          end
        end
        ST_MID1: begin
          if (mid_ev) begin
            mid_count <= next_mid_count;
          end else if (high_ev) begin
            mid_count <= 4'h0;
            unique case (decode_key(high_count, mid_count))
              SEL_OP_DOWN, SEL_OP_BIT: begin
                state <= locked ? ST_DEAD : ST_TRY;
                sel   <= locked ? SEL_NONE : decode_key(high_count, mid_count);
              end
              SEL_OP_BLOW: begin
                state <= locked ? ST_DEAD : ST_BLOW;
                sel   <= SEL_OP_BLOW;
              end
              SEL_HYS, SEL_PARITY, SEL_LOCK: begin
                state <= ST_TRY;
                sel   <= decode_key(high_count, mid_count);
              end
              SEL_NONE, SEL_OP_UP: begin
                state <= ST_DEAD;
                sel   <= SEL_NONE;
              end
            endcase
          end
        end
        ST_TRY: begin
          if (mid_ev) begin
            mid_count <= next_mid_count;
          end else if (high_ev) begin
            mid_count <= 4'h0;
            if (mid_count == `KEY_MID_BLOW && sel != SEL_OP_DOWN && sel != SEL_OP_BIT) begin
              state <= ST_BLOW;
            end else begin
              state <= ST_DEAD;
            end
          end
        end
        ST_BLOW: begin
          if (blow_ev || high_ev) begin
            state <= ST_DEAD;
          end
        end
        ST_DEAD: begin
          state <= ST_DEAD;
        end
        default: begin
          state <= ST_DEAD;
        end
      endcase
    end
  end

  // try mode trial codes, cleared on power cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      try_on    <= 1'b0;
      trial_op  <= 6'h00;
      trial_hys <= 2'h0;
      trial_par <= 1'b0;
    end else begin
      if (state == ST_HIGH && high_ev && high_count == 2'h1 && !locked) begin
        try_on   <= 1'b1;
        trial_op <= `TRIAL_CODE_START;
      end else if (state == ST_MID1 && mid_ev && sel == SEL_OP_UP) begin
        trial_op <= trial_op + 6'h01;
      end else if (state == ST_MID1 && high_ev) begin
        unique case (decode_key(high_count, mid_count))
          SEL_OP_DOWN: begin
            try_on   <= !locked;
            trial_op <= `OP_CODE_MAX;
          end
          SEL_OP_BIT: begin
            try_on   <= !locked;
            trial_op <= `TRIAL_CODE_START;
          end
          SEL_HYS: begin
            try_on    <= 1'b1;
            trial_hys <= `HYS_CODE_START;
          end
          SEL_PARITY: begin
            try_on    <= 1'b1;
            trial_par <= 1'b1;
          end
          SEL_LOCK: begin
            try_on <= 1'b1;
          end
          SEL_NONE, SEL_OP_UP, SEL_OP_BLOW: begin
            try_on <= 1'b0;
          end
        endcase
      end else if (state == ST_TRY && mid_ev) begin
        unique case (sel)
          SEL_OP_DOWN: trial_op <= trial_op - 6'h01;
          SEL_OP_BIT:  trial_op <= bit_step(trial_op);
          SEL_HYS:     trial_hys <= locked ? trial_hys : trial_hys + 2'h1;
          SEL_PARITY:  trial_par <= ~trial_par;
          SEL_NONE, SEL_OP_UP, SEL_LOCK, SEL_OP_BLOW: trial_op <= trial_op;
        endcase
      end
      if (state == ST_TRY && high_ev) begin
        try_on <= 1'b0;
      end
    end
  end

  // fuse margin check selection, try mode only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      check_mode <= CHK_OFF;
    end else if (state == ST_TRY && sel == SEL_HYS && mid_ev) begin
      if (next_mid_count == `CHECK_MID_LOW) check_mode <= CHK_LOW;
      else if (next_mid_count == `CHECK_MID_HIGH) check_mode <= CHK_HIGH;
      else check_mode <= CHK_OFF;
    end else if (state != ST_TRY) begin
      check_mode <= CHK_OFF;
    end
  end

  // marginal fuse detection and supply current flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      marginal            <= 1'b0;
      supply_current_bump <= 1'b0;
    end else begin
      unique case (check_mode)
        CHK_LOW:  marginal <= |(~fuse & fuse_sense_low);
        CHK_HIGH: marginal <= |(fuse & ~fuse_sense_high);
        default:  marginal <= 1'b0;
      endcase
      supply_current_bump <= marginal && (check_mode != CHK_OFF);
    end
  end

  // blow mode one-hot address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blow_addr <= 8'h01;
    end else if (state != ST_BLOW) begin
      blow_addr <= 8'h01;
    end else if (mid_ev) begin
      blow_addr <= {blow_addr[6:0], 1'b0};
    end
  end

  // fuse blow decision and drive, one per power cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blow_done       <= 1'b0;
      fuse_blow_pulse <= 1'b0;
      fuse_blow_sel   <= '0;
    end else begin
      fuse_blow_pulse <= 1'b0;
      fuse_blow_sel   <= '0;
      if (state == ST_BLOW && blow_ev && !blow_done) begin
        blow_done       <= 1'b1;
        fuse_blow_pulse <= 1'b1;
        unique case (sel)
          SEL_OP_BLOW: begin
            if (!locked) fuse_blow_sel[`FUSE_OP_LSB +: 6] <= blow_addr[5:0];
          end
          SEL_HYS: begin
            if (!locked) fuse_blow_sel[`FUSE_HYS_LSB +: 2] <= blow_addr[1:0];
          end
          SEL_PARITY: begin
            fuse_blow_sel[`FUSE_PARITY_BIT] <= ^fuse[`FUSE_PARITY_BIT-1:0];
          end
          SEL_LOCK: begin
            fuse_blow_sel[`FUSE_LOCK_BIT] <= blow_addr[`LOCK_ADDR_BIT];
          end
          SEL_NONE, SEL_OP_UP, SEL_OP_DOWN, SEL_OP_BIT: fuse_blow_pulse <= 1'b0;
        endcase
      end
    end
  end

  // fuse array, kept across power cycles
  always_ff @(posedge clk) begin
    if (fuse_erase) begin
      fuse <= '0;
    end else if (fuse_blow_pulse) begin
      fuse <= fuse | fuse_blow_sel;
    end
  end

  // software control register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_disable <= `CONTROL_RESET;
    end else if (reg_wr && reg_addr == `REG_CONTROL) begin
      key_disable <= reg_wdata[0];
    end
  end

  // trim codes applied to the analog path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      operate_point     <= 6'h00;
      switch_hysteresis <= 2'h0;
      parity_trim       <= 1'b0;
    end else begin
      operate_point     <= (try_on && (sel == SEL_OP_UP || sel == SEL_OP_DOWN ||
                            sel == SEL_OP_BIT)) ? trial_op : fuse[`FUSE_OP_LSB +: 6];
      switch_hysteresis <= (try_on && sel == SEL_HYS && !locked) ? trial_hys
                                                                 : fuse[`FUSE_HYS_LSB +: 2];
      parity_trim       <= (try_on && sel == SEL_PARITY) ? trial_par
                                                         : fuse[`FUSE_PARITY_BIT];
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= 32'h0000_0000;
      unique case (reg_addr)
        `REG_STATUS: begin
          reg_rdata[`ST_LOCK_BIT]          <= locked;
          reg_rdata[`ST_TRY_BIT]           <= try_on;
          reg_rdata[`ST_BLOWN_BIT]         <= blow_done;
          reg_rdata[`ST_MARGINAL_BIT]      <= marginal;
          reg_rdata[`ST_CHECK_LSB +: 2]    <= check_mode;
          reg_rdata[`ST_STATE_LSB +: 3]    <= state;
          reg_rdata[`ST_SEL_LSB +: 3]      <= sel;
        end
        `REG_CODES: begin
          reg_rdata[5:0]  <= trial_op;
          reg_rdata[9:8]  <= trial_hys;
          reg_rdata[16]   <= trial_par;
        end
        `REG_FUSES: begin
          reg_rdata[`FUSE_COUNT-1:0] <= fuse;
        end
        `REG_CONTROL: begin
          reg_rdata[0] <= key_disable;
        end
        default: begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : fuse_trim_key_programmer

// file: include/fuse_trim_defines.svh
`ifndef FUSE_TRIM_DEFINES_SVH
`define FUSE_TRIM_DEFINES_SVH

// clock and pulse timing
`define CLK_PERIOD_NS           100
`define BLOW_PULSE_DURATION_US  100
`define BLOW_PULSE_CYCLES \
  ((`BLOW_PULSE_DURATION_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// supply level coding on the sampled supply input
`define LEVEL_NORMAL            2'h0
`define LEVEL_MID               2'h1
`define LEVEL_HIGH              2'h2

// key pulse counts
`define KEY_MID_PARITY          4'h1
`define KEY_MID_HYS             4'h3
`define KEY_MID_DOWN            4'h4
`define KEY_MID_LOCK            4'h5
`define KEY_MID_BITWISE         4'h9
`define KEY_MID_BLOW            4'hb
`define CHECK_MID_LOW           4'h7
`define CHECK_MID_HIGH          4'h8

// fuse array layout
`define FUSE_COUNT              10
`define FUSE_OP_LSB             0
`define FUSE_HYS_LSB            6
`define FUSE_PARITY_BIT         8
`define FUSE_LOCK_BIT           9
`define LOCK_ADDR_BIT           4

// trial codes
`define OP_CODE_MAX             6'h3f
`define TRIAL_CODE_START        6'h01
`define HYS_CODE_START          2'h1

// register offsets
`define REG_STATUS              8'h00
`define REG_CODES               8'h04
`define REG_FUSES               8'h08
`define REG_CONTROL             8'h0c

// status field positions
`define ST_LOCK_BIT             0
`define ST_TRY_BIT              1
`define ST_BLOWN_BIT            2
`define ST_MARGINAL_BIT         3
`define ST_CHECK_LSB            4
`define ST_STATE_LSB            8
`define ST_SEL_LSB              12

// reset values
`define CONTROL_RESET           1'h0

`endif

// file: include/fuse_trim_pkg.sv
package fuse_trim_pkg;

  // key tracking states, gray along the key path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_HIGH  = 3'h1,
    ST_MID1  = 3'h3,
    ST_TRY   = 3'h2,
    ST_BLOW  = 3'h6,
    ST_DEAD  = 3'h7
  } key_state_t;

  // selected virtual register
  typedef enum logic [2:0] {
    SEL_NONE    = 3'h0,
    SEL_OP_UP   = 3'h1,
    SEL_OP_DOWN = 3'h2,
    SEL_OP_BIT  = 3'h3,
    SEL_HYS     = 3'h4,
    SEL_PARITY  = 3'h5,
    SEL_LOCK    = 3'h6,
    SEL_OP_BLOW = 3'h7
  } reg_sel_t;

  // fuse margin check
  typedef enum logic [1:0] {
    CHK_OFF  = 2'h0,
    CHK_LOW  = 2'h1,
    CHK_HIGH = 2'h2
  } check_t;

endpackage : fuse_trim_pkg

// file: logic/supply_pulse_classifier.sv
`timescale 1ns/1ps
`include "fuse_trim_defines.svh"

module supply_pulse_classifier (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // sampled supply level
  input  wire logic [1:0] supply_level,
  // pulse events at the falling edge
  output logic            mid_event,
  output logic            high_event,
  output logic            blow_event
);

  localparam logic [11:0] BLOW_CYCLES = 12'(`BLOW_PULSE_CYCLES);

  logic [1:0]  prev_level;
  logic [11:0] high_len;

  // previous level for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_level <= `LEVEL_NORMAL;
    end else begin
      prev_level <= supply_level;
    end
  end

  // length of the current high pulse, saturating
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      high_len <= 12'h000;
    end else if (supply_level == `LEVEL_HIGH) begin
      if (high_len != 12'hfff) begin
        high_len <= high_len + 12'h001;
      end
    end else begin
      high_len <= 12'h000;
    end
  end

  // classify each pulse when it ends
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mid_event  <= 1'b0;
      high_event <= 1'b0;
      blow_event <= 1'b0;
    end else begin
      mid_event  <= (prev_level == `LEVEL_MID) && (supply_level != `LEVEL_MID);
      high_event <= (prev_level == `LEVEL_HIGH) && (supply_level != `LEVEL_HIGH)
                    && (high_len < BLOW_CYCLES);
      blow_event <= (prev_level == `LEVEL_HIGH) && (supply_level != `LEVEL_HIGH)
                    && (high_len >= BLOW_CYCLES);
    end
  end

endmodule : supply_pulse_classifier

// file: tb/fuse_trim_sva.sv
`timescale 1ns/1ps
`include "fuse_trim_defines.svh"

module fuse_trim_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // watched inputs
  input wire logic [1:0]  supply_level,
  input wire logic        fuse_erase,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  // watched outputs
  input wire logic [31:0] reg_rdata,
  input wire logic [5:0]  operate_point,
  input wire logic [1:0]  switch_hysteresis,
  input wire logic        parity_trim,
  input wire logic        supply_current_bump,
  input wire logic        fuse_blow_pulse,
  input wire logic [9:0]  fuse_blow_sel
);
  logic        blown_seen;
  logic        lock_seen;
  logic [10:0] hi_run;
  logic [10:0] hi_last;

  // a blow already happened this power cycle
  always_ff @(posedge clk) begin
    if (sys_rst) blown_seen <= 1'b0;
    else if (fuse_blow_pulse) blown_seen <= 1'b1;
  end
  // lock fuse blown since the array was erased
  always_ff @(posedge clk) begin
    if (fuse_erase) lock_seen <= 1'b0;
    else if (fuse_blow_pulse && fuse_blow_sel[`FUSE_LOCK_BIT]) lock_seen <= 1'b1;
  end
  // length of the running high pulse
  always_ff @(posedge clk) begin
    if (sys_rst || supply_level != `LEVEL_HIGH) hi_run <= 11'h0;
    else if (hi_run != 11'h7ff) hi_run <= hi_run + 11'h1;
  end
  // length of the last finished high pulse
  always_ff @(posedge clk) begin
    if (sys_rst) hi_last <= 11'h0;
    else if (supply_level != `LEVEL_HIGH && hi_run != 11'h0) hi_last <= hi_run;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // supply resting at normal level
  sequence s_quiet;
    (supply_level == `LEVEL_NORMAL) [*6];
  endsequence
  // lock fuse blown, out of reset
  sequence s_locked;
    (lock_seen && !sys_rst) [*4];
  endsequence

  property p_onehot; fuse_blow_pulse |-> $onehot0(fuse_blow_sel); endproperty
  a_onehot: assert property (p_onehot) else $error("blow select not one-hot");
  property p_single; fuse_blow_pulse |=> !fuse_blow_pulse; endproperty
  a_single: assert property (p_single) else $error("blow pulse too long");
  property p_one_blow; fuse_blow_pulse |-> !blown_seen; endproperty
  a_one_blow: assert property (p_one_blow) else $error("second blow in power cycle");
  property p_long; fuse_blow_pulse |-> hi_last >= 11'(`BLOW_PULSE_CYCLES); endproperty
  a_long: assert property (p_long) else $error("blow after short high pulse");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_unmapped; reg_rd && reg_addr > `REG_CONTROL |=> reg_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_quiet;
    s_quiet |-> $stable(operate_point) && $stable(switch_hysteresis) && $stable(parity_trim);
  endproperty
  a_quiet: assert property (p_quiet) else $error("trim moved without pulse");
  property p_locked; s_locked |=> $stable(operate_point) && $stable(switch_hysteresis); endproperty
  a_locked: assert property (p_locked) else $error("trim moved while locked");
  property p_lock_field; lock_seen && fuse_blow_pulse |-> fuse_blow_sel[7:0] == 8'h0; endproperty
  a_lock_field: assert property (p_lock_field) else $error("field blown while locked");
  property p_rst;
    $fell(sys_rst) |-> !fuse_blow_pulse && !supply_current_bump && reg_rdata == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule : fuse_trim_sva

bind fuse_trim_key_programmer fuse_trim_sva u_fuse_trim_sva (
  .clk(clk), .sys_rst(sys_rst), .supply_level(supply_level), .fuse_erase(fuse_erase),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .operate_point(operate_point), .switch_hysteresis(switch_hysteresis),
  .parity_trim(parity_trim), .supply_current_bump(supply_current_bump),
  .fuse_blow_pulse(fuse_blow_pulse), .fuse_blow_sel(fuse_blow_sel)
);

// file: tb/pgm.sv
`timescale 1ns/1ps
`include "fuse_trim_defines.svh"

module pgm #(
  parameter int GAP_CYCLES     = 6,
  parameter int POST_BLOW_WAIT = 20
) (
  // clock
  input  wire logic       clk,
  // supply pin level
  output logic      [1:0] supply_level
);
  initial supply_level = `LEVEL_NORMAL;

  // one pulse, then normal supply for the gap
  task automatic pulse(input logic [1:0] lvl, input int width);
    repeat (width) @(posedge clk) supply_level <= lvl;
    @(posedge clk) supply_level <= `LEVEL_NORMAL;
    repeat (GAP_CYCLES) @(posedge clk);
  endtask : pulse
  // mid pulses of random width
  task automatic mids(input int n);
    repeat (n) pulse(`LEVEL_MID, 1 + $urandom_range(0, 3));
  endtask : mids
  // key: highs, mids, highs
  task automatic seq(input int h1, input int m, input int h2);
    repeat (h1) pulse(`LEVEL_HIGH, 1 + $urandom_range(0, 3));
    mids(m);
    repeat (h2) pulse(`LEVEL_HIGH, 1 + $urandom_range(0, 3));
  endtask : seq
  // long high pulse, then the wait before power may drop
  task automatic blow;
    pulse(`LEVEL_HIGH, `BLOW_PULSE_CYCLES + 4);
    repeat (POST_BLOW_WAIT) @(posedge clk);
  endtask : blow
  // lock key, blow key, lock address, blow
  task automatic lock_part;
    seq(1, 5, 1);
    seq(0, 11, 1);
    mids(`LOCK_ADDR_BIT);
    blow();
  endtask : lock_part
endmodule : pgm

// file: tb/tb.sv
`timescale 1ns/1ps
`include "fuse_trim_defines.svh"

module tb;
  logic        clk, sys_rst, fuse_erase, reg_wr, reg_rd, parity_trim;
  logic        supply_current_bump, fuse_blow_pulse;
  logic [1:0]  supply_level, switch_hysteresis;
  logic [5:0]  operate_point;
  logic [7:0]  reg_addr;
  logic [9:0]  fuse_sense_high, fuse_sense_low, fuse_blow_sel, fuses, hi_flip, lo_flip, last_sel;
  logic [31:0] reg_wdata, reg_rdata;
  int          n_mismatch, check_count, n, k;

  fuse_trim_key_programmer u_fuse_trim_key_programmer (
    .clk(clk), .sys_rst(sys_rst), .supply_level(supply_level), .fuse_erase(fuse_erase),
    .fuse_sense_high(fuse_sense_high), .fuse_sense_low(fuse_sense_low),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .operate_point(operate_point),
    .switch_hysteresis(switch_hysteresis), .parity_trim(parity_trim),
    .supply_current_bump(supply_current_bump), .fuse_blow_pulse(fuse_blow_pulse),
    .fuse_blow_sel(fuse_blow_sel)
  );
  pgm u_pgm (.clk(clk), .supply_level(supply_level));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // fuse sense with injected faults, blow monitor
  always @(posedge clk) begin
    fuse_sense_high <= fuses ^ hi_flip;
    fuse_sense_low <= fuses ^ lo_flip;
    if (fuse_blow_pulse === 1'b1) last_sel <= fuse_blow_sel;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic trims(input logic [5:0] op, input logic [1:0] hy, input logic par);
    chk("operate_point", 32'(op), 32'(operate_point));
    chk("switch_hysteresis", 32'(hy), 32'(switch_hysteresis));
    chk("parity_trim", 32'(par), 32'(parity_trim));
  endtask : trims
  task automatic bump(input logic exp);
    chk("supply_current_bump", 32'(exp), 32'(supply_current_bump));
  endtask : bump
  task automatic blow_chk(input logic [9:0] sel);
    chk("fuse_blow_sel", 32'(sel), 32'(last_sel));
    fuses = fuses | sel;
    last_sel <= 10'h0;
  endtask : blow_chk
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", exp, reg_rdata);
  endtask : reg_check
  task automatic power_cycle;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : power_cycle
  // bitwise register walk: one-hot from bit 0, then zero
  function automatic logic [5:0] bit_code(input int i);
    return (i % 7 == 6) ? 6'h0 : 6'(1 << (i % 7));
  endfunction : bit_code
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    sys_rst = 1'b1;
    fuse_erase = 1'b1;
    {fuses, hi_flip, lo_flip, last_sel, fuse_sense_high, fuse_sense_low} = '0;
    {n_mismatch, check_count} = '0;
    void'($urandom(32'h0bf86e25));
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    fuse_erase <= 1'b0;
    repeat (4) @(posedge clk);
    trims(6'h0, 2'h0, 1'b0);
    reg_write(8'h10 + 8'($urandom_range(0, 239)), $urandom | 32'h1);
    reg_check(`REG_CONTROL, 32'h0);
    reg_check(8'h10 + 8'($urandom_range(0, 239)), 32'h0);
    u_pgm.seq(2, 0, 0);
    trims(6'h1, 2'h0, 1'b0);
    n = $urandom_range(62, 70);
    u_pgm.mids(n);
    trims(6'(n + 1), 2'h0, 1'b0);
    power_cycle();
    trims(6'h0, 2'h0, 1'b0);
    u_pgm.seq(2, 4, 1);
    trims(6'h3f, 2'h0, 1'b0);
    n = $urandom_range(1, 70);
    u_pgm.mids(n);
    trims(6'(63 - n), 2'h0, 1'b0);
    power_cycle();
    u_pgm.seq(2, 9, 1);
    for (int i = 0; i < 8; i++) begin
      trims(bit_code(i), 2'h0, 1'b0);
      u_pgm.mids(1);
    end
    power_cycle();
    u_pgm.seq(1, 3, 1);
    for (int i = 0; i < 5; i++) begin
      trims(6'h0, 2'(i + 1), 1'b0);
      u_pgm.mids(1);
    end
    power_cycle();
    u_pgm.seq(1, 1, 1);
    for (int i = 0; i < 3; i++) begin
      trims(6'h0, 2'h0, 1'((i + 1) % 2));
      u_pgm.mids(1);
    end
    power_cycle();
    reg_write(`REG_CONTROL, {31'($urandom), 1'b1});
    reg_check(`REG_CONTROL, 32'h1);
    u_pgm.seq(2, 0, 0);
    trims(6'h0, 2'h0, 1'b0);
    reg_write(`REG_CONTROL, {31'($urandom), 1'b0});
    u_pgm.seq(2, 0, 0);
    trims(6'h1, 2'h0, 1'b0);
    k = $urandom_range(0, 5);
    power_cycle();
    u_pgm.seq(2, 11, 1);
    u_pgm.mids(k);
    u_pgm.blow();
    blow_chk(10'(1 << k));
    u_pgm.seq(2, 11, 1);
    u_pgm.blow();
    blow_chk(10'h0);
    power_cycle();
    trims(fuses[5:0], 2'h0, 1'b0);
    u_pgm.seq(1, 1, 1);
    u_pgm.seq(0, 11, 1);
    u_pgm.blow();
    blow_chk({1'b0, ^fuses[7:0], 8'h0});
    power_cycle();
    u_pgm.seq(1, 3, 1);
    u_pgm.seq(0, 11, 1);
    u_pgm.mids(1);
    u_pgm.blow();
    blow_chk(10'h080);
    power_cycle();
    trims(fuses[5:0], fuses[7:6], fuses[8]);
    reg_check(`REG_FUSES, 32'(fuses));
    lo_flip <= 10'h200 | (10'($urandom) & ~fuses);
    u_pgm.mids(7);
    bump(1'b0);
    power_cycle();
    u_pgm.seq(1, 3, 1);
    u_pgm.mids(7);
    bump(1'b1);
    power_cycle();
    lo_flip <= 10'h0;
    u_pgm.seq(1, 3, 1);
    u_pgm.mids(7);
    bump(1'b0);
    power_cycle();
    u_pgm.lock_part();
    blow_chk(10'h200);
    power_cycle();
    reg_check(`REG_STATUS, 32'h1);
    u_pgm.seq(2, 0, 0);
    u_pgm.mids(3);
    trims(fuses[5:0], fuses[7:6], fuses[8]);
    power_cycle();
    u_pgm.seq(2, 11, 1);
    u_pgm.blow();
    blow_chk(10'h0);
    power_cycle();
    u_pgm.seq(1, 3, 1);
    u_pgm.seq(0, 11, 1);
    u_pgm.blow();
    blow_chk(10'h0);
    power_cycle();
    hi_flip <= 10'h200 | (10'($urandom) & fuses);
    u_pgm.seq(1, 3, 1);
    u_pgm.mids(8);
    trims(fuses[5:0], fuses[7:6], fuses[8]);
    bump(1'b1);
    power_cycle();
    hi_flip <= 10'h0;
    u_pgm.seq(1, 3, 1);
    u_pgm.mids(8);
    bump(1'b0);
    final_report();
  end
endmodule : tb
